// [design/ddrwp_write_port.sv]
`timescale 1ns/10ps
// How it works
// - Write data captured on true clock rise and again on complementary rise.
// - Data width is 8, 9, 18 or 36 bits from bit 0.
// - Write port select sampled only on true clock rising edges.
// - Select low requests a write; sampled low starts a write.
// - Select high deselects the port; write data ignored that cycle.
// - In 8-bit parts two nibble selects; first one governs bits 3:0.
// - Nibbles sampled high during a write leave memory unchanged.
// - Lane selects sampled on the same edge as their data word.
// - Lane select n masks 9 bits: 8:0, 17:9, 26:18, 35:27.
// - Lane sampled high: its data ignored, stored contents unaltered.
// - Address is write address at complementary rise; ignored when deselected.
module ddrwp_write_port import ddrwp_pkg::*; #(
  parameter int DATA_W = DDRWP_DATA_W_DEF,
  parameter int ADDR_W = DDRWP_ADDR_W_DEF
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  // Pin side, sampled as data on clk
  input wire logic k,
  input wire logic k_n,
  input wire logic write_port_select_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic low_nibble_mask_n,
  input wire logic high_nibble_mask_n,
  input wire logic lane0_mask_n,
  input wire logic lane1_mask_n,
  input wire logic lane2_mask_n,
  input wire logic lane3_mask_n,
  // Array side
  output logic write_ready,
  output logic overrun,
  output logic cmd_valid,
  input wire logic cmd_ready,
  output logic [ADDR_W-1:0] cmd_addr,
  output logic [DATA_W-1:0] cmd_data0,
  output logic [DATA_W-1:0] cmd_en0,
  output logic [DATA_W-1:0] cmd_data1,
  output logic [DATA_W-1:0] cmd_en1
);

  localparam int ENTRY_W = ADDR_W + 4 * DATA_W;
  // Entry layout, lowest field first
  localparam int EN1_LSB = 0;
  localparam int DATA1_LSB = DATA_W;
  localparam int EN0_LSB = 2 * DATA_W;
  localparam int DATA0_LSB = 3 * DATA_W;
  localparam int ADDR_LSB = 4 * DATA_W;

  // ----------------------------------------
  // Mask expansion
  // ----------------------------------------
  // Active-low selects become per-bit write enables
  function automatic logic [DATA_W-1:0] expand_mask(input logic [DDRWP_MASK_PINS-1:0] mask_n);
    logic [DATA_W-1:0] en;
    int lane_w;
    en = '0;
    lane_w = (DATA_W == DDRWP_NIBBLE_CFG) ? DDRWP_NIBBLE_W : DDRWP_LANE_W;
    for (int i = 0; i < DATA_W; i++) begin
      en[i] = ~mask_n[i / lane_w];
    end
    return en;
  endfunction : expand_mask

  // Occupancy after this cycle; a push into a full buffer is already refused
  function automatic logic [1:0] buf_count_next(input logic [1:0] cnt, input logic pushed, input logic popped);
    logic [1:0] nxt;
    nxt = cnt;
    if (pushed && !popped) begin
      nxt = cnt + 2'h1;
    end else if (popped && !pushed) begin
      nxt = cnt - 2'h1;
    end
    return nxt;
  endfunction : buf_count_next

  // ----------------------------------------
  // Edge detection on the input clock pair
  // ----------------------------------------
  logic k_prev_reg;
  logic k_n_prev_reg;
  wire logic k_rise = k & ~k_prev_reg;
  wire logic k_n_rise = k_n & ~k_n_prev_reg;

  wire logic nibble_cfg = (DATA_W == DDRWP_NIBBLE_CFG);
  wire logic [1:0] nibble_pins_n = {high_nibble_mask_n, low_nibble_mask_n};
  wire logic [DDRWP_MASK_PINS-1:0] lane_pins_n = {lane3_mask_n, lane2_mask_n, lane1_mask_n, lane0_mask_n};
  // Unused slots read as masked, so they can never enable a bit
  wire logic [DDRWP_MASK_PINS-1:0] mask_pins_n = nibble_cfg ? {2'h3, nibble_pins_n} : lane_pins_n;
  // Selects paired with data sampled on the same edge
  wire logic [DATA_W-1:0] beat_en = expand_mask(mask_pins_n);

  // ----------------------------------------
  // Burst capture
  // ----------------------------------------
  ddrwp_state_type state_reg;
  ddrwp_state_type state_next;
  logic [DATA_W-1:0] data0_reg;
  logic [DATA_W-1:0] en0_reg;
  logic overrun_reg;

  // Select looked at only on true clock rise
  wire logic start_write = k_rise & ~write_port_select_n;
  // Write address taken at complementary rise
  wire logic burst_done = (state_reg == DDRWP_HAVE_FIRST) & k_n_rise;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      DDRWP_IDLE: begin
        if (start_write) begin
          state_next = DDRWP_HAVE_FIRST;
        end
      end
      DDRWP_HAVE_FIRST: begin
        if (k_n_rise) begin
          state_next = DDRWP_IDLE;
        end
      end
    endcase
  end

  // ----------------------------------------
  // Clock pair history
  // ----------------------------------------
  // Reset low: pins idling low give no false rise after reset
  always_ff @(posedge clk) begin
    if (srst) begin
      k_prev_reg <= 1'h0;
    end else if (ce) begin
      k_prev_reg <= k;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      k_n_prev_reg <= 1'h0;
    end else if (ce) begin
      k_n_prev_reg <= k_n;
    end
  end

  // ----------------------------------------
  // Burst state
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg <= DDRWP_IDLE;
    end else if (ce) begin
      state_reg <= state_next;
    end
  end

  // First word at true clock rise
  // Deselected cycles leave the holding word untouched
  // A later start before the second beat simply replaces the first word
  always_ff @(posedge clk) begin
    if (srst) begin
      data0_reg <= '0;
    end else if (ce && start_write) begin
      data0_reg <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      en0_reg <= '0;
    end else if (ce && start_write) begin
      en0_reg <= beat_en;
    end
  end

  // ----------------------------------------
  // Two-entry buffer toward the array
  // ----------------------------------------
  // Whole bursts are buffered so the array sees address and both beats together
  logic [ENTRY_W-1:0] buf_mem [DDRWP_BUF_DEPTH];
  logic wr_ptr_reg;
  logic rd_ptr_reg;
  logic [1:0] count_reg;
  wire logic buf_full = (count_reg == 2'(DDRWP_BUF_DEPTH));
  wire logic buf_empty = (count_reg == DDRWP_CNT_RESET);
  wire logic push = burst_done & ~buf_full;
  wire logic pop = cmd_valid & cmd_ready;
  wire logic lost = burst_done & buf_full;
  wire logic [1:0] count_next = buf_count_next(count_reg, push, pop);
  // Masked bits carry no enable, array keeps them
  wire logic [ENTRY_W-1:0] push_entry = {addr, data0_reg, en0_reg, wdata, beat_en};
  wire logic [ENTRY_W-1:0] head = buf_mem[rd_ptr_reg];

  always_ff @(posedge clk) begin
    if (ce && push) begin
      buf_mem[wr_ptr_reg] <= push_entry;
    end
  end

  // ----------------------------------------
  // Buffer pointers
  // ----------------------------------------
  // Depth two: one bit each, wrapping by toggling
  always_ff @(posedge clk) begin
    if (srst) begin
      wr_ptr_reg <= DDRWP_PTR_RESET;
    end else if (ce) begin
      if (push) begin
        wr_ptr_reg <= ~wr_ptr_reg;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rd_ptr_reg <= DDRWP_PTR_RESET;
    end else if (ce) begin
      if (pop) begin
        rd_ptr_reg <= ~rd_ptr_reg;
      end
    end
  end

  // ----------------------------------------
  // Buffer occupancy
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      count_reg <= DDRWP_CNT_RESET;
    end else if (ce) begin
      count_reg <= count_next;
    end
  end

  // ----------------------------------------
  // Overrun flag
  // ----------------------------------------
  // Sticky: the pins cannot be stalled, so a burst into a full buffer is lost
  always_ff @(posedge clk) begin
    if (srst) begin
      overrun_reg <= 1'h0;
    end else if (ce) begin
      if (lost) begin
        overrun_reg <= 1'h1;
      end
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign write_ready = ~buf_full;
  assign overrun = overrun_reg;
  assign cmd_valid = ~buf_empty;
  assign cmd_addr = head[ADDR_LSB +: ADDR_W];
  assign cmd_data0 = head[DATA0_LSB +: DATA_W];
  assign cmd_en0 = head[EN0_LSB +: DATA_W];
  assign cmd_data1 = head[DATA1_LSB +: DATA_W];
  assign cmd_en1 = head[EN1_LSB +: DATA_W];

endmodule : ddrwp_write_port

// [design/ddrwp_pkg.sv]
package ddrwp_pkg;
  // ----------------------------------------
  // Port widths
  // ----------------------------------------
  localparam int DDRWP_DATA_W_DEF = 36;
  localparam int DDRWP_ADDR_W_DEF = 21;
  localparam int DDRWP_MASK_PINS = 4;
  localparam int DDRWP_NIBBLE_W = 4;
  localparam int DDRWP_LANE_W = 9;
  localparam int DDRWP_NIBBLE_CFG = 8;
  localparam int DDRWP_SINGLE_LANE_CFG = 9;
  // ----------------------------------------
  // Buffer
  // ----------------------------------------
  localparam int DDRWP_BUF_DEPTH = 2;
  localparam logic [1:0] DDRWP_CNT_RESET = 2'h0;
  localparam logic DDRWP_PTR_RESET = 1'h0;

  typedef enum logic [0:0] {
    DDRWP_IDLE,
    DDRWP_HAVE_FIRST
  } ddrwp_state_type;
endpackage : ddrwp_pkg

// [verification/ddrwp_write_port_assertions.sv]
`timescale 1ns/10ps
module ddrwp_write_port_assertions (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic k,
  input wire logic k_n,
  input wire logic write_port_select_n,
  input wire logic write_ready,
  input wire logic overrun,
  input wire logic cmd_valid,
  input wire logic cmd_ready
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  chk_reset_state: assert property (disable iff (1'b0) srst |=> !cmd_valid && write_ready && !overrun)
    else $error("reset state wrong");
  chk_push_on_kn: assert property ($rose(cmd_valid) |-> $past(k_n) && !$past(k_n, 2))
    else $error("push not on k_n rise");
  chk_deselect_idle: assert property ($rose(k) && write_port_select_n && !cmd_valid |=> !cmd_valid [*4])
    else $error("deselected write stored");
  chk_head_holds: assert property (cmd_valid && !cmd_ready |=> cmd_valid)
    else $error("entry lost");
  chk_pop_frees: assert property (ce && cmd_valid && cmd_ready && !write_ready |=> write_ready)
    else $error("pop gave no room");
  chk_empty_room: assert property (!cmd_valid |-> write_ready)
    else $error("empty but not ready");
  chk_overrun_cause: assert property ($rose(overrun) |-> !$past(write_ready) && $past(k_n))
    else $error("overrun without full push");
  chk_overrun_sticky: assert property (overrun |=> overrun)
    else $error("overrun cleared");
  chk_freeze_hold: assert property (!ce |=> $stable(cmd_valid) && $stable(overrun))
    else $error("state moved while frozen");
endmodule : ddrwp_write_port_assertions
bind ddrwp_write_port ddrwp_write_port_assertions chk (.clk(clk), .srst(srst), .ce(ce), .k(k), .k_n(k_n),
  .write_port_select_n(write_port_select_n), .write_ready(write_ready), .overrun(overrun),
  .cmd_valid(cmd_valid), .cmd_ready(cmd_ready));

// [verification/ddrwp_ctrl_model.sv]
`timescale 1ns/10ps
module ddrwp_ctrl_model (
  input wire logic clk,
  output logic k,
  output logic k_n,
  output logic sel_n,
  output logic [20:0] addr,
  output logic [35:0] wdata,
  output logic [3:0] lane_n
);
  initial {k, k_n, sel_n, addr, wdata, lane_n} = '0;
  // word0 on k, word1 on k_n
  task automatic burst(input logic s, input logic [20:0] a, input logic [35:0] x0, x1, input logic [3:0] m0, m1);
    k = 1; sel_n = s; wdata = x0; lane_n = m0;
    @(posedge clk) #1;
    k = 0; sel_n = ~s; wdata = ~x0; lane_n = ~m0;
    @(posedge clk) #1;
    k_n = 1; addr = a; wdata = x1; lane_n = m1;
    @(posedge clk) #1;
    k_n = 0; addr = ~a; wdata = ~x1; lane_n = ~m1;
  endtask : burst
endmodule : ddrwp_ctrl_model

// [verification/ddrwp_write_port_tb.sv]
`timescale 1ns/10ps
module ddrwp_write_port_tb import ddrwp_pkg::*;;
  logic clk = 0, srst = 1, cmd_ready = 0, ce = 1, k, k_n, sel_n, wr_rdy, ovr, cv;
  logic wr_rdy8, ovr8, cv8;
  logic [20:0] c_addr8;
  logic [7:0] d0_8, e0_8, d1_8, e1_8;
  logic [20:0] addr, c_addr;
  logic [35:0] wdata, d0, e0, d1, e1;
  logic [3:0] lane_n;
  int error_cnt = 0, n_tests = 0, cyc = 0;
  always #5 clk = ~clk;
  ddrwp_ctrl_model m (.clk(clk), .k(k), .k_n(k_n), .sel_n(sel_n), .addr(addr), .wdata(wdata), .lane_n(lane_n));
  ddrwp_write_port #(.DATA_W(8), .ADDR_W(21)) dut8 (.clk(clk), .srst(srst), .ce(ce), .k(k), .k_n(k_n),
    .write_port_select_n(sel_n), .addr(addr), .wdata(wdata[7:0]), .low_nibble_mask_n(lane_n[0]),
    .high_nibble_mask_n(lane_n[1]), .lane0_mask_n(1'b0), .lane1_mask_n(1'b0), .lane2_mask_n(1'b0),
    .lane3_mask_n(1'b0), .write_ready(wr_rdy8), .overrun(ovr8), .cmd_valid(cv8), .cmd_ready(cmd_ready),
    .cmd_addr(c_addr8), .cmd_data0(d0_8), .cmd_en0(e0_8), .cmd_data1(d1_8), .cmd_en1(e1_8));
  ddrwp_write_port dut (.clk(clk), .srst(srst), .ce(ce), .k(k), .k_n(k_n), .write_port_select_n(sel_n),
    .addr(addr), .wdata(wdata), .low_nibble_mask_n(1'b1), .high_nibble_mask_n(1'b1), .lane0_mask_n(lane_n[0]),
    .lane1_mask_n(lane_n[1]), .lane2_mask_n(lane_n[2]), .lane3_mask_n(lane_n[3]), .write_ready(wr_rdy),
    .overrun(ovr), .cmd_valid(cv), .cmd_ready(cmd_ready), .cmd_addr(c_addr), .cmd_data0(d0), .cmd_en0(e0),
    .cmd_data1(d1), .cmd_en1(e1));
  function automatic logic [35:0] en(input logic [3:0] mk);
    for (int i = 0; i < 36; i++) en[i] = ~mk[i / 9];
  endfunction : en
  function automatic logic [7:0] en8(input logic [3:0] mk);
    for (int i = 0; i < 8; i++) en8[i] = ~mk[i / 4];
  endfunction : en8
  task automatic chk(input string s, input logic [35:0] x, g);
    n_tests++;
    if (g !== x) begin
      error_cnt++;
      $display("[FAIL] %s exp %h got %h", s, x, g);
    end
  endtask : chk
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : close_out
  task automatic head(input logic [20:0] a, input logic [35:0] x0, x1, input logic [3:0] m0, m1);
    chk("valid", 36'h1, 36'(cv));
    chk("addr", 36'(a), 36'(c_addr));
    chk("en0", en(m0), e0);
    chk("en1", en(m1), e1);
    chk("data0", x0 & en(m0), d0 & e0);
    chk("data1", x1 & en(m1), d1 & e1);
  endtask : head
  task automatic t_deselect;
    m.burst(1, 21'h0000A, 36'h1, 36'h2, 4'h0, 4'h0);
    repeat (3) @(posedge clk);
    #1 chk("idle", 36'h0, 36'(cv));
    $display("t_deselect done");
  endtask : t_deselect
  task automatic t_fill;
    m.burst(0, 21'h1FFFFF, 36'hFFFFFFFFF, 36'h123456789, 4'h0, 4'hA);
    @(posedge clk) #1;
    m.burst(0, 21'h00005, 36'hABCDEF012, 36'h0F0F0F0F0, 4'h5, 4'h3);
    @(posedge clk) #1 chk("full", 36'h0, 36'(wr_rdy));
    m.burst(0, 21'h00007, 36'h0, 36'h0, 4'h0, 4'h0);
    @(posedge clk) #1 chk("overrun", 36'h1, 36'(ovr));
    head(21'h1FFFFF, 36'hFFFFFFFFF, 36'h123456789, 4'h0, 4'hA);
    $display("t_fill done");
  endtask : t_fill
  task automatic t_drain;
    cmd_ready = 1;
    @(posedge clk) #1 head(21'h00005, 36'hABCDEF012, 36'h0F0F0F0F0, 4'h5, 4'h3);
    @(posedge clk) #1 cmd_ready = 0;
    chk("empty", 36'h3, 36'({cv, wr_rdy, ovr}));
    $display("t_drain done");
  endtask : t_drain
  task automatic t_nibble;
    m.burst(0, 21'h0ABCD, 36'h0000000A5, 36'h00000003C, 4'h1, 4'h2);
    chk("nib valid", 36'h1, 36'(cv8));
    chk("nib addr", 36'h0ABCD, 36'(c_addr8));
    chk("nib en0", 36'(en8(4'h1)), 36'(e0_8));
    chk("nib en1", 36'(en8(4'h2)), 36'(e1_8));
    chk("nib data", 36'({8'hA5 & en8(4'h1), 8'h3C & en8(4'h2)}), 36'({d0_8 & e0_8, d1_8 & e1_8}));
    chk("nib flags", 36'h3, 36'({wr_rdy8, ovr8}));
    cmd_ready = 1;
    @(posedge clk) #1 cmd_ready = 0;
    chk("nib empty", 36'h0, 36'({cv8, cv}));
    $display("t_nibble done");
  endtask : t_nibble
  task automatic t_freeze;
    ce = 0;
    m.burst(0, 21'h00033, 36'h111111111, 36'h222222222, 4'h0, 4'h0);
    chk("frozen idle", 36'h0, 36'(cv));
    ce = 1;
    m.burst(0, 21'h00044, 36'h333333333, 36'h444444444, 4'h0, 4'h0);
    ce = 0;
    cmd_ready = 1;
    repeat (2) @(posedge clk);
    #1 chk("frozen hold", 36'h1, 36'(cv));
    head(21'h00044, 36'h333333333, 36'h444444444, 4'h0, 4'h0);
    ce = 1;
    @(posedge clk) #1 cmd_ready = 0;
    chk("freeze pop", 36'h0, 36'(cv));
    $display("t_freeze done");
  endtask : t_freeze
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 500) begin
      error_cnt++;
      close_out();
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    #1 srst = 0;
    t_deselect();
    t_fill();
    t_drain();
    t_nibble();
    t_freeze();
    close_out();
  end
endmodule : ddrwp_write_port_tb
